// ===== hw/vsc_top.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module vsc_top import vsc_pkg::*; (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  input wire logic frame_select,
  input wire logic serial_clock,
  input wire logic serial_din,
  output logic serial_dout_o,
  output logic serial_dout_oe,
  // Display pins
  output logic [10:0] character_position,
  output logic [15:0] segment_out,
  output logic [5:0] scan_drive_line,
  // Key, switch and lamp pins
  input wire logic [3:0] key_return,
  input wire logic [3:0] general_input_pin,
  output logic [3:0] lamp_output
);
  // Pin synchronisers
  logic [1:0] fs_s_q;
  logic [1:0] sck_s_q;
  logic [1:0] sdi_s_q;
  logic [3:0] key_s1_q;
  logic [3:0] key_s2_q;
  logic [3:0] gpi_s1_q;
  logic [3:0] gpi_s2_q;
  logic fs_d_q;
  logic sck_d_q;

  // Serial receiver and transmitter
  logic [2:0] bit_q;
  logic [6:0] sh_q;
  logic first_q;
  logic rd_act_q;
  logic [1:0] rd_idx_q;
  logic sdo_q;

  // Command state
  vsc_ctrl_t ctrl_q;
  vsc_data_t data_q;
  logic [3:0] lamp_q;

  // APB registers
  logic [15:0] cfg_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // Scan and memory
  logic [23:0] keys;
  logic [3:0] ram_raddr;
  logic [15:0] ram_rdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_s_q <= 2'h3;
      sck_s_q <= 2'h3;
      sdi_s_q <= 2'h0;
      key_s1_q <= 4'h0;
      key_s2_q <= 4'h0;
      gpi_s1_q <= 4'h0;
      gpi_s2_q <= 4'h0;
      fs_d_q <= 1'b1;
      sck_d_q <= 1'b1;
    end else begin
      fs_s_q <= {fs_s_q[0], frame_select};
      sck_s_q <= {sck_s_q[0], serial_clock};
      sdi_s_q <= {sdi_s_q[0], serial_din};
      key_s1_q <= key_return;
      key_s2_q <= key_s1_q;
      gpi_s1_q <= general_input_pin;
      gpi_s2_q <= gpi_s1_q;
      fs_d_q <= fs_s_q[1];
      sck_d_q <= sck_s_q[1];
    end
  end

  wire logic fs = fs_s_q[1];
  wire logic sdi = sdi_s_q[1];
  wire logic fs_edge = fs ^ fs_d_q;
  wire logic sck_rise = !fs && sck_s_q[1] && !sck_d_q;
  wire logic sck_fall = !fs && !sck_s_q[1] && sck_d_q;
  wire logic [7:0] rx_byte = {sdi, sh_q};
  wire logic byte_done = sck_rise && (bit_q == 3'h7);

  // Command decode
  // class in top two bits
  wire logic [1:0] cls = rx_byte[7:6];
  wire logic is_cmd = byte_done && first_q && !fs_edge;
  wire logic is_data = byte_done && !first_q && !fs_edge;
  wire logic cmd_mode = is_cmd && (cls == `VSC_CLS_MODE);
  wire logic cmd_data = is_cmd && (cls == `VSC_CLS_DATA);
  wire logic cmd_dctl = is_cmd && (cls == `VSC_CLS_DCTL);
  wire logic cmd_addr = is_cmd && (cls == `VSC_CLS_ADDR);
  wire logic mode_new = cmd_mode && (rx_byte[2:0] != ctrl_q.mode);
  wire logic rd_op = rx_byte[1];

  wire logic addr_ok = (data_q.addr < `VSC_RAM_BYTES);
  wire logic wr_disp = is_data && (data_q.op == `VSC_OP_WDISP) && addr_ok;
  wire logic wr_lamp = is_data && (data_q.op == `VSC_OP_WLAMP);
  wire logic [1:0] ram_wbe = data_q.addr[0] ? 2'h2 : 2'h1;

  // Read byte selection
  wire logic [7:0] key_byte = keys[rd_idx_q * 8 +: 8];
  wire logic [7:0] gpi_byte = {4'h0, gpi_s2_q};
  wire logic [7:0] rd_byte =
    (data_q.op == `VSC_OP_RKEY) ? key_byte : gpi_byte;

  // Serial receiver; any strobe edge starts a fresh frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q <= 3'h0;
      sh_q <= 7'h0;
      first_q <= 1'b1;
    end else if (fs_edge) begin
      bit_q <= 3'h0;
      sh_q <= 7'h0;
      first_q <= 1'b1;
    end else if (sck_rise) begin
      sh_q <= rx_byte[7:1];
      bit_q <= bit_q + 3'h1;
      if (byte_done) begin
        first_q <= 1'b0;
      end
    end
  end

  // Transmitter: open-drain, so only a zero bit is driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_act_q <= 1'b0;
      rd_idx_q <= 2'h0;
      sdo_q <= 1'b1;
    end else if (fs_edge) begin
      rd_act_q <= 1'b0;
      rd_idx_q <= 2'h0;
      sdo_q <= 1'b1;
    end else begin
      if (cmd_data) begin
        rd_act_q <= rd_op;
        rd_idx_q <= 2'h0;
      end
      if (sck_fall && rd_act_q) begin
        sdo_q <= rd_byte[bit_q];
      end
      if (byte_done && rd_act_q && !first_q) begin
        rd_idx_q <= (rd_idx_q == `VSC_KEY_BYTES - 2'h1) ?
          2'h0 : rd_idx_q + 2'h1;
      end
    end
  end

  assign serial_dout_o = 1'b0;
  assign serial_dout_oe = rd_act_q && !sdo_q;

  // Command and data state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q.mode <= `VSC_MODE_RST;
      ctrl_q.disp_on <= 1'b0;
      ctrl_q.dim <= `VSC_DIM_RST;
      data_q.op <= `VSC_OP_WDISP;
      data_q.noinc <= 1'b0;
      data_q.addr <= `VSC_ADDR_RST;
      lamp_q <= `VSC_LAMP_RST;
    end else begin
      if (mode_new) begin
        ctrl_q.mode <= rx_byte[2:0];
        ctrl_q.disp_on <= 1'b0;
      end
      if (cmd_data) begin
        data_q.op <= rx_byte[1:0];
        data_q.noinc <= rx_byte[`VSC_NOINC_BIT];
      end
      if (cmd_addr) begin
        data_q.addr <= rx_byte[4:0];
      end
      if (cmd_dctl) begin
        ctrl_q.disp_on <= rx_byte[`VSC_DISP_ON_BIT];
        ctrl_q.dim <= rx_byte[2:0];
      end
      if (wr_disp && !data_q.noinc) begin
        data_q.addr <= data_q.addr + 5'h1;
      end
      if (wr_lamp) begin
        lamp_q <= rx_byte[3:0];
      end
    end
  end

  assign lamp_output = ~lamp_q;

  // even byte low half, odd high
  vsc_ram u_ram (
    .pclk(pclk),
    .we(wr_disp),
    .wbe(ram_wbe),
    .waddr(data_q.addr[4:1]),
    .wdata(rx_byte),
    .raddr(ram_raddr),
    .rdata_q(ram_rdata)
  );

  vsc_scan u_scan (
    .pclk(pclk),
    .presetn(presetn),
    .tick_div(cfg_q),
    .ctrl(ctrl_q),
    .ram_raddr(ram_raddr),
    .ram_rdata(ram_rdata),
    .key_ret(key_s2_q),
    .grid_q(character_position),
    .seg_q(segment_out),
    .ks_q(scan_drive_line),
    .keys_q(keys)
  );

  // APB slave: zero wait states, data captured in setup phase
  wire logic apb_setup = psel && !penable;
  wire logic apb_wr = psel && penable && pwrite;
  wire logic hit_cfg = (paddr == `VSC_REG_CFG);
  wire logic hit_sta = (paddr == `VSC_REG_STATUS);
  wire logic hit_key = (paddr == `VSC_REG_KEYS);
  wire logic hit_any = hit_cfg || hit_sta || hit_key;
  wire logic [31:0] status_w = {12'h0, lamp_q, !addr_ok, data_q.addr,
    data_q.noinc, data_q.op, ctrl_q.dim, ctrl_q.disp_on, ctrl_q.mode};
  wire logic [31:0] rd_mux =
    hit_cfg ? {16'h0, cfg_q} :
    hit_sta ? status_w :
    hit_key ? {8'h0, keys} : 32'h0;
  wire logic cfg_wr_ok = (pwdata[15:0] != 16'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 16'(`VSC_TICK_DIV);
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      if (apb_setup) begin
        prdata_q <= pwrite ? 32'h0 : rd_mux;
        pslverr_q <= !hit_any || (pwrite && !hit_cfg);
      end
      // A zero divider would wrap to one scan tick per 65536 cycles, so it is refused
      if (apb_wr && hit_cfg && cfg_wr_ok) begin
        cfg_q <= pwdata[15:0];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q && psel && penable;
endmodule // vsc_top

// ===== pkg/vsc_params.svh
`ifndef VSC_PARAMS_SVH
`define VSC_PARAMS_SVH

// Command byte classes (top two bits)
`define VSC_CLS_MODE 2'h0
`define VSC_CLS_DATA 2'h1
`define VSC_CLS_DCTL 2'h2
`define VSC_CLS_ADDR 2'h3

// Data setting operations (low two bits)
`define VSC_OP_WDISP 2'h0
`define VSC_OP_WLAMP 2'h1
`define VSC_OP_RKEY 2'h2
`define VSC_OP_RGPI 2'h3

// Command field positions
`define VSC_NOINC_BIT 2
`define VSC_DISP_ON_BIT 3

// Power-on values
`define VSC_MODE_RST 3'h7
`define VSC_ADDR_RST 5'h00
`define VSC_DIM_RST 3'h0
`define VSC_LAMP_RST 4'hf

// Display RAM and display geometry
`define VSC_RAM_BYTES 5'h16
`define VSC_DIGITS_MAX 11
`define VSC_SEGS_MAX 16
`define VSC_MIN_DIGITS 4'h4
`define VSC_PIN_BUDGET 5'h16
`define VSC_SEG_ONLY_DIGITS 4'h6
`define VSC_KEY_LINES 6
`define VSC_KEY_RETURNS 4
`define VSC_KEY_BYTES 2'h3
`define VSC_SLOT_LAST 4'hf

// Scan timing: oscillator rate against pclk
`define VSC_OSC_KHZ 500
`define VSC_PCLK_KHZ 100000
`define VSC_TICK_DIV (`VSC_PCLK_KHZ / `VSC_OSC_KHZ)

// APB register offsets (byte addresses)
`define VSC_REG_CFG 12'h000
`define VSC_REG_STATUS 12'h004
`define VSC_REG_KEYS 12'h008

`endif

// ===== pkg/vsc_pkg.sv
package vsc_pkg;
  `include "vsc_params.svh"

  typedef struct packed {
    logic [2:0] mode;
    logic disp_on;
    logic [2:0] dim;
  } vsc_ctrl_t;

  typedef struct packed {
    logic [1:0] op;
    logic noinc;
    logic [4:0] addr;
  } vsc_data_t;

  typedef enum logic [1:0] {SC_IDLE, SC_DIGIT, SC_KEY} vsc_scan_e;

  // Digits driven in a display mode: 4 .. 11
  function automatic logic [3:0] vsc_ndig(input logic [2:0] mode);
    return `VSC_MIN_DIGITS + {1'b0, mode};
  endfunction

  // Segments in a display mode: 16 down to 11
  function automatic logic [4:0] vsc_nseg(input logic [2:0] mode);
    logic [3:0] d;
    d = vsc_ndig(mode);
    if (d <= `VSC_SEG_ONLY_DIGITS) return 5'h10;
    return `VSC_PIN_BUDGET - {1'b0, d};
  endfunction

  // Lit ticks out of sixteen for each dimming step
  function automatic logic [4:0] vsc_dim_width(input logic [2:0] dim);
    case (dim)
      3'h0: return 5'h01;
      3'h1: return 5'h02;
      3'h2: return 5'h04;
      3'h3: return 5'h0a;
      3'h4: return 5'h0b;
      3'h5: return 5'h0c;
      3'h6: return 5'h0d;
      default: return 5'h0e;
    endcase
  endfunction
endpackage

// ===== hw/vsc_ram.sv
`timescale 1ns/10ps
// Display memory: one 16-bit word per digit, byte writes
module vsc_ram import vsc_pkg::*; #(
  parameter int DEPTH = `VSC_DIGITS_MAX,
  parameter int AW = 4
) (
  // Clock
  input wire logic pclk,
  // Write port
  input wire logic we,
  input wire logic [1:0] wbe,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [15:0] rdata_q
);
  logic [15:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (we && wbe[0]) begin
      mem[waddr][7:0] <= wdata;
    end
    if (we && wbe[1]) begin
      mem[waddr][15:8] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule // vsc_ram

// ===== hw/vsc_scan.sv
`timescale 1ns/10ps
// Multiplexed refresh and key matrix scan
module vsc_scan import vsc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic [15:0] tick_div,
  input wire vsc_ctrl_t ctrl,
  // Display memory
  output logic [3:0] ram_raddr,
  input wire logic [15:0] ram_rdata,
  // Pins (key returns already synchronised)
  input wire logic [3:0] key_ret,
  output logic [10:0] grid_q,
  output logic [15:0] seg_q,
  output logic [5:0] ks_q,
  // Key results
  output logic [23:0] keys_q
);
  vsc_scan_e state_q;
  logic [15:0] div_q;
  logic [3:0] pos_q;
  logic [3:0] sub_q;
  logic [23:0] kbuf_q;
  // Slot state delayed one cycle to line up with the registered RAM read
  logic [3:0] pos_p_q;
  logic dig_p_q;
  logic lit_p_q;

  wire logic tick = (div_q >= tick_div - 16'h1);
  wire logic [3:0] ndig = vsc_ndig(ctrl.mode);
  wire logic [4:0] nseg = vsc_nseg(ctrl.mode);
  wire logic [16:0] seg_mask_w = (17'h1 << nseg) - 17'h1;
  wire logic lit = ({1'b0, sub_q} < vsc_dim_width(ctrl.dim));
  wire logic [2:0] ks_idx = sub_q[3:1];
  wire logic ks_act = (ks_idx < 3'(`VSC_KEY_LINES));
  wire logic slot_end = tick && (sub_q == `VSC_SLOT_LAST);

  assign ram_raddr = pos_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SC_IDLE;
      div_q <= 16'h0;
      pos_q <= 4'h0;
      sub_q <= 4'h0;
    end else if (!ctrl.disp_on) begin
      state_q <= SC_IDLE;
      div_q <= 16'h0;
      pos_q <= 4'h0;
      sub_q <= 4'h0;
    end else begin
      div_q <= tick ? 16'h0 : div_q + 16'h1;
      if (tick) begin
        sub_q <= sub_q + 4'h1;
      end
      case (state_q)
        SC_IDLE: begin
          state_q <= SC_DIGIT;
        end
        SC_DIGIT: begin
          if (slot_end) begin
            if (pos_q >= ndig - 4'h1) begin
              state_q <= SC_KEY;
            end else begin
              pos_q <= pos_q + 4'h1;
            end
          end
        end
        SC_KEY: begin
          if (slot_end) begin
            state_q <= SC_DIGIT;
            pos_q <= 4'h0;
          end
        end
        default: state_q <= SC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kbuf_q <= 24'h0;
      keys_q <= 24'h0;
    end else if (state_q == SC_KEY && tick) begin
      if (ks_act && sub_q[0]) begin
        kbuf_q[ks_idx * 4 +: 4] <= key_ret;
      end
      if (sub_q == `VSC_SLOT_LAST) begin
        keys_q <= kbuf_q;
      end
    end
  end

  // Outputs registered so the pins never glitch between slots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grid_q <= 11'h0;
      seg_q <= 16'h0;
      ks_q <= 6'h0;
      pos_p_q <= 4'h0;
      dig_p_q <= 1'b0;
      lit_p_q <= 1'b0;
    end else begin
      pos_p_q <= pos_q;
      dig_p_q <= (state_q == SC_DIGIT);
      lit_p_q <= lit;
      grid_q <= 11'h0;
      seg_q <= 16'h0;
      ks_q <= 6'h0;
      if (dig_p_q) begin
        grid_q <= 11'h1 << pos_p_q;
        if (lit_p_q) begin
          seg_q <= ram_rdata & seg_mask_w[15:0];
        end
      end else if (state_q == SC_KEY && ks_act) begin
        ks_q <= 6'h1 << ks_idx;
        seg_q <= {10'h0, 6'h1 << ks_idx};
      end
    end
  end
endmodule // vsc_scan

// ===== tb/vsc_top_monitor.sv
`timescale 1ns/10ps
module vsc_top_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Link and pins
  input wire logic frame_select,
  input wire logic serial_dout_o,
  input wire logic serial_dout_oe,
  input wire logic [10:0] character_position,
  input wire logic [15:0] segment_out,
  input wire logic [5:0] scan_drive_line,
  input wire logic [3:0] lamp_output
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire mapped = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  a_write_ro_err: assert property (acc && pwrite && paddr != 12'h000
    |-> pslverr)
    else $error("read-only write not refused");
  a_read_ok: assert property (acc && !pwrite && mapped |-> !pslverr)
    else $error("mapped read refused");
  a_dout_open_drain: assert property (serial_dout_o == 1'b0)
    else $error("data out drives high");
  a_dout_idle_off: assert property (frame_select [*8] |-> !serial_dout_oe)
    else $error("data out active between frames");
  a_dout_in_frame: assert property ($rose(serial_dout_oe) |-> !frame_select)
    else $error("data out starts outside a frame");
  a_grid_one_hot: assert property ($onehot0(character_position))
    else $error("several digits driven");
  a_key_drive_seg: assert property (|scan_drive_line |->
    $onehot(scan_drive_line) && segment_out[5:0] == scan_drive_line
    && character_position == 11'h000)
    else $error("key drive not on shared segments");
  a_lamp_reset: assert property ($rose(presetn) |-> lamp_output == 4'h0)
    else $error("lamp lit after reset");
endmodule // vsc_top_monitor

bind vsc_top vsc_top_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .frame_select(frame_select),
  .serial_dout_o(serial_dout_o), .serial_dout_oe(serial_dout_oe),
  .character_position(character_position), .segment_out(segment_out),
  .scan_drive_line(scan_drive_line), .lamp_output(lamp_output));

// ===== tb/vsc_host.sv
`timescale 1ns/10ps
module vsc_host (
  // Clock
  input wire logic pclk,
  // Link
  output logic frame_select,
  output logic serial_clock,
  output logic serial_din,
  input wire logic dout_line
);
  initial begin
    frame_select = 1'b1;
    serial_clock = 1'b1;
    serial_din = 1'b0;
  end
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic open_frame;
    frame_select <= 1'b0;
    ticks(8);
  endtask
  // Data line flips once released so no stale bit is trusted
  task automatic close_frame;
    ticks(100);
    frame_select <= 1'b1;
    serial_din <= ~serial_din;
    ticks(100);
  endtask
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      serial_clock <= 1'b0;
      serial_din <= b[i];
      ticks(4);
      serial_clock <= 1'b1;
      ticks(4);
    end
  endtask
  task automatic recv_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      serial_clock <= 1'b0;
      ticks(4);
      b[i] = dout_line;
      serial_clock <= 1'b1;
      ticks(4);
    end
  endtask
endmodule // vsc_host

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, dout_o, dout_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, s;
  logic errv;
  logic [3:0] key_ret, gpi, lamps;
  logic [10:0] grid;
  logic [15:0] seg;
  logic [5:0] ks;
  wire frame_select, serial_clock, serial_din;
  wire dout_line = dout_oe ? dout_o : 1'b1;
  int miscompares = 0;
  int checked = 0;

  vsc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_select(frame_select), .serial_clock(serial_clock),
    .serial_din(serial_din), .serial_dout_o(dout_o),
    .serial_dout_oe(dout_oe), .character_position(grid),
    .segment_out(seg), .scan_drive_line(ks), .key_return(key_ret),
    .general_input_pin(gpi), .lamp_output(lamps));
  vsc_host host (.pclk(pclk), .frame_select(frame_select),
    .serial_clock(serial_clock), .serial_din(serial_din),
    .dout_line(dout_line));

  initial begin
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] c, input int n, input logic [23:0] d);
    host.open_frame();
    host.send_bits(c, 8);
    for (int i = 0; i < n; i++) host.send_bits(d[8*i +: 8], 8);
    host.close_frame();
    apb(1'b0, 12'h004, 32'h0);
  endtask
  task automatic rframe(input logic [7:0] c, input int n, input logic [7:0] e);
    logic [7:0] b;
    host.open_frame();
    host.send_bits(c, 8);
    host.ticks(100);
    for (int i = 0; i < n; i++) begin
      host.recv_byte(b);
      chk("read byte", {24'h0, e}, {24'h0, b});
    end
    host.close_frame();
  endtask

  task automatic t_reset;
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h000f0007, rdv);
    chk("lamps", 32'h0, {28'h0, lamps});
    apb(1'b0, 12'h000, 32'h0);
    chk("cfg", 32'h000000c8, rdv);
  endtask
  task automatic t_regs;
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b0, 12'h000, 32'h0);
    chk("cfg", 32'h2, rdv);
    apb(1'b1, 12'h004, 32'h0);
    chk("ro err", 32'h1, {31'h0, errv});
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, errv});
  endtask
  task automatic t_lamps;
    frame(8'h41, 1, 24'h0000a5);
    chk("lamps", 32'ha, {28'h0, lamps});
    chk("lamp raw", 32'h5, {28'h0, rdv[19:16]});
  endtask
  task automatic t_ctrl;
    frame(8'h8f, 0, 24'h0);
    chk("ctrl", 32'h7f, {25'h0, rdv[6:0]});
    frame(8'h07, 0, 24'h0);
    chk("same mode", 32'h7f, {25'h0, rdv[6:0]});
    frame(8'h03, 0, 24'h0);
    chk("new mode", 32'h73, {25'h0, rdv[6:0]});
  endtask
  task automatic t_addr;
    frame(8'h40, 0, 24'h0);
    frame(8'hc0, 3, 24'h332211);
    chk("addr inc", 32'h3, {27'h0, rdv[14:10]});
    frame(8'h44, 0, 24'h0);
    frame(8'hc2, 2, 24'h005566);
    chk("addr fixed", 32'h2, {27'h0, rdv[14:10]});
    frame(8'hd6, 0, 24'h0);
    chk("addr bad", 32'h1, {31'h0, rdv[15]});
    frame(8'hc0, 0, 24'h0);
    chk("addr good", 32'h0, {31'h0, rdv[15]});
  endtask
  task automatic t_partial;
    s = rdv;
    host.open_frame();
    host.send_bits(8'h8f, 5);
    host.close_frame();
    apb(1'b0, 12'h004, 32'h0);
    chk("partial", s, rdv);
    host.send_bits(8'h55, 3);
    frame(8'h43, 0, 24'h0);
    chk("op", 32'h3, {30'h0, rdv[8:7]});
  endtask
  task automatic t_switch;
    @(posedge pclk);
    gpi <= 4'h9;
    rframe(8'h43, 2, 8'h09);
  endtask
  task automatic t_keys;
    @(posedge pclk);
    key_ret <= 4'h5;
    frame(8'h8f, 0, 24'h0);
    host.ticks(1500);
    apb(1'b0, 12'h008, 32'h0);
    chk("keys", 32'h00555555, rdv);
    for (int i = 0; i < 600 && !(grid == 11'h1 && seg != 16'h0); i++) begin
      @(posedge pclk);
    end
    chk("digit 0 segs", 32'h2211, {16'h0, seg});
    rframe(8'h42, 4, 8'h55);
  endtask

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    key_ret = 4'h0;
    gpi = 4'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_lamps();
    t_ctrl();
    t_addr();
    t_partial();
    t_switch();
    t_keys();
    print_verdict();
  end

  // Whole run is near 7k cycles
  initial begin
    repeat (80000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end
endmodule // testbench
